// ---- include/dbgh_pkg.sv ----
// constants for the scan debug host controller
`default_nettype none
package dbgh_pkg;
    // host command register map (byte addresses)
    localparam logic [11:0] DBGH_CTRL_OFF = 12'h000;
    localparam logic [11:0] DBGH_IR_OFF = 12'h004;
    localparam logic [11:0] DBGH_DR_OUT_OFF = 12'h008;
    localparam logic [11:0] DBGH_DR_IN_OFF = 12'h00c;
    localparam logic [11:0] DBGH_STAT_OFF = 12'h010;
    localparam logic [11:0] DBGH_LEN_OFF = 12'h014;
    // control bit positions
    localparam int DBGH_GO_BIT = 0;
    localparam int DBGH_KIND_BIT = 1;
    localparam int DBGH_TLR_BIT = 2;
    localparam int DBGH_SWD_BIT = 3;
    localparam int DBGH_HOLD_BIT = 4;
    localparam int DBGH_RST_BIT = 5;
    localparam int DBGH_SKIP_BIT = 6;
    localparam int DBGH_CTRL_W = 7;
    // status bit positions
    localparam int DBGH_BUSY_BIT = 0;
    localparam int DBGH_SWMODE_BIT = 1;
    localparam int DBGH_DONE_BIT = 2;
    // device instructions and registers
    localparam logic [3:0] DBGH_INS_SAMPLE = 4'h1;
    localparam logic [3:0] DBGH_INS_INTEST = 4'h4;
    localparam logic [3:0] DBGH_IR_RESET = 4'h0;
    localparam logic [31:0] DBGH_AP_SYSBUS = 32'h00000000;
    localparam logic [31:0] DBGH_AP_SYSMGR = 32'h00000001;
    localparam logic [7:0] DBGH_TARGET_LOC_OFF = 8'h0c;
    localparam logic [7:0] DBGH_CHIP_ID_EXT_OFF = 8'hf4;
    // link timing: test clock half period in pclk cycles
    localparam int DBGH_TCK_HALF = 4;
    localparam logic [2:0] DBGH_TCK_HALF_M1 = 3'(DBGH_TCK_HALF - 1);
    localparam logic [5:0] DBGH_LEN_RESET = 6'h20;
    localparam logic [3:0] DBGH_IR_LEN = 4'h4;
    localparam logic [6:0] DBGH_TLR_TMS = 7'h05;   // five ones
    localparam logic [15:0] DBGH_SWD_SEQ = 16'he79e;
    localparam logic [6:0] DBGH_SWD_LEN = 7'h40;   // 50 ones, seq, 15 ones, lsb first
    typedef enum logic [3:0] {
        DBGH_IDLE, DBGH_RESET, DBGH_SEL_DR, DBGH_SEL_IR, DBGH_CAPTURE, DBGH_SHIFT,
        DBGH_EXIT1, DBGH_UPDATE, DBGH_RUN, DBGH_SWITCH
    } dbgh_state_e;
endpackage
`default_nettype wire

// ---- logic/dbgh_ctrl.sv ----
// scan debug host: apb command registers driving a device test access port
//
// Function
// [RULE_01] device starts in scan mode; host may send switch sequence for serial wire
// [RULE_02] trace only in serial wire mode; host stops reading data-out then
// [RULE_03] access port select 0 is system bus, 1 is system manager
// [RULE_04] sample/preload code 0001; captured instruction pattern p00s
// [RULE_05] internal test code 0100; captured instruction pattern p001
// [RULE_06] internal test samples logic outputs, update applies to inputs
// [RULE_07] system manager access needs running cpu clock and power-up request
// [RULE_08] set module-on before other registers; disabled port ignores accesses
// [RULE_09] module-off bit clears manager registers and stops its clock
// [RULE_10] target location register at 0x0c, resets zero, word aligned
// [RULE_11] read-only chip identification extension at 0xf4
// [RULE_12] mode-select 1,1,0 returns from shift to idle; update latches
// [RULE_13] mode-select 1,0,0 enters data shift; low mode-select keeps shifting
// [RULE_14] latched data register output updates only in update state
// [RULE_15] instruction scan may go straight into data scan
// [RULE_16] identification instruction default after reset
// [RULE_17] four mandatory instructions; bypass gives shortest path
// [RULE_18] device pins go high impedance on entering reset
// [RULE_19] preload safe values with sample/preload before external test
// [RULE_20] erase-all clears memories then flash then protection; poll done
// [RULE_21] test clock low at reset release holds core in reset
// [RULE_22] after erase keep test clock high while releasing reset
// [RULE_23] debug logic held reset while state machine in test-logic-reset
// [RULE_24] first falling test-clock edge after reset marks debugger present
// [RULE_25] standard sixteen-state transitions on rising test-clock edges
//
// link timing of one data scan of n bits, f1 being the first tck fall after go:
//   f1 tms high: idle to data select
//   f2 tms low: select to capture
//   f3 tms low: capture to shift; the device loads its word on this rise
//   f4 first tdi bit out; the device shows its first tdo bit on this fall
//   f5 on: each fall takes the tdo bit of the fall before, through the flops
//   the fall that carries the last tdi bit raises tms toward exit1
//   the exit1 fall takes the last tdo bit, the update fall latches the result
//   the run step ends on a rising tck, so tck rests high after a full half
// an instruction scan adds one high step for the instruction column
// limitations: one sequence at a time, at most 32 data bits, no pause states
// the device's own registers are reached only through scans built by software
// the two pin flops add latency, which the one-fall lag on tdo absorbs
// trade-off: a slow but fixed test clock keeps every step easy to reason about
//
// The APB interface to the registers was left to the implementer.
`default_nettype none
module dbgh_ctrl
    import dbgh_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    output logic reset_n_out
);
    logic [DBGH_CTRL_W-1:0] ctrl;
    logic [3:0] ir_word;
    logic [31:0] dr_out;
    logic [31:0] dr_in;
    logic [5:0] dr_len;
    logic sw_mode;
    logic done;
    dbgh_state_e state;
    logic [2:0] div;
    logic [6:0] cnt;
    logic is_ir;
    logic skip_idle;
    logic tdo_s1;
    logic tdo_s2;
    logic wr_en;
    logic rd_en;
    logic go_req;
    logic tick;
    logic fall;
    logic [31:0] shreg;
    logic [5:0] last_bit;

    // single-cycle access: pready held high, so every access ends in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign go_req = wr_en && (paddr == DBGH_CTRL_OFF) && pwdata[DBGH_GO_BIT];
    assign tick = (div == DBGH_TCK_HALF_M1);
    assign fall = tick && tck;
    assign last_bit = is_ir ? 6'(DBGH_IR_LEN - 4'h1) : 6'(dr_len - 6'h01);

    // unmapped offsets report an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (paddr)
                DBGH_CTRL_OFF, DBGH_IR_OFF, DBGH_DR_OUT_OFF,
                DBGH_DR_IN_OFF, DBGH_STAT_OFF, DBGH_LEN_OFF: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // tdo is a pin from the device: two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdo_s1 <= 1'b0;
            tdo_s2 <= 1'b0;
        end else begin
            tdo_s1 <= tdo;
            tdo_s2 <= tdo_s1;
        end
    end

    // control, instruction, data and length registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
            ir_word <= DBGH_IR_RESET;
            dr_out <= '0;
            dr_len <= DBGH_LEN_RESET;
        end else if (wr_en) begin
            case (paddr)
                // go bit self-clears; only sticky options are kept
                DBGH_CTRL_OFF: ctrl <= pwdata[DBGH_CTRL_W-1:0] & 7'h7e;
                // [RULE_19] preload before external test
                DBGH_IR_OFF: ir_word <= pwdata[3:0];
                // [RULE_03] access port words
                // [RULE_08] module-on word first
                // [RULE_20] erase word, poll done
                DBGH_DR_OUT_OFF: dr_out <= pwdata;
                // zero length would wrap last_bit to 63 and shift 64 bits, so it is forced to one
                DBGH_LEN_OFF: dr_len <= (pwdata[5:0] == 6'h00) ? 6'h01 : pwdata[5:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    // read mux, data from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                DBGH_CTRL_OFF: prdata <= {25'h0, ctrl};
                DBGH_IR_OFF: prdata <= {28'h0, ir_word};
                DBGH_DR_OUT_OFF: prdata <= dr_out;
                DBGH_DR_IN_OFF: prdata <= dr_in;
                DBGH_STAT_OFF: prdata <= {29'h0, done, sw_mode, state != DBGH_IDLE};
                DBGH_LEN_OFF: prdata <= {26'h0, dr_len};
                default: prdata <= '0;
            endcase
        end
    end

    // divider for the test clock, which this end makes; runs only while a sequence runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= '0;
            tck <= 1'b1;
        end else if (state == DBGH_IDLE) begin
            div <= '0;
            // rule 21/22: rest level of tck chosen by the hold-core option
            // [RULE_21] hold tck low
            tck <= !ctrl[DBGH_HOLD_BIT];
        end else begin
            div <= tick ? 3'h0 : div + 3'h1;
            if (tick) begin
                tck <= !tck;
            end
        end
    end

    // [RULE_22] reset release level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_n_out <= 1'b0;
        end else begin
            reset_n_out <= !ctrl[DBGH_RST_BIT];
        end
    end

    // sequence engine: tms/tdi change on tck falling, device samples on rising
    // [RULE_25] walk standard tap states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DBGH_IDLE;
            cnt <= '0;
            tms <= 1'b1;
            tdi <= 1'b0;
            is_ir <= 1'b0;
            skip_idle <= 1'b0;
            shreg <= '0;
        end else begin
            case (state)
                DBGH_IDLE: begin
                    // a go while a sequence runs is not looked at
                    if (go_req) begin
                        cnt <= '0;
                        is_ir <= pwdata[DBGH_KIND_BIT];
                        skip_idle <= pwdata[DBGH_SKIP_BIT];
                        if (pwdata[DBGH_SWD_BIT]) begin
                            state <= DBGH_SWITCH;
                        end else if (pwdata[DBGH_TLR_BIT]) begin
                            state <= DBGH_RESET;
                        end else if (!sw_mode) begin
                            // refused scans stay here; the flag process reports them
                            state <= DBGH_SEL_DR;
                        end
                    end
                end
                // [RULE_23] five ones reach test-logic-reset
                DBGH_RESET: if (fall) begin
                    tms <= 1'b1;
                    cnt <= cnt + 7'h01;
                    if (cnt == DBGH_TLR_TMS) begin
                        tms <= 1'b0;
                        state <= DBGH_RUN;
                    end
                end
                // [RULE_01] switch sequence after line reset
                DBGH_SWITCH: if (fall) begin
                    cnt <= cnt + 7'h01;
                    if (cnt >= 7'h32 && cnt < 7'h42) begin
                        tms <= DBGH_SWD_SEQ[4'(cnt - 7'h32)];
                    end else begin
                        tms <= 1'b1;
                    end
                    if (cnt == DBGH_SWD_LEN + 7'h10) begin
                        // finish on a rising tck so the last low half is a full one
                        state <= DBGH_RUN;
                        tms <= 1'b1;
                    end
                end
                // [RULE_13] tms 1 then 0 reaches capture
                DBGH_SEL_DR: if (fall) begin
                    tms <= 1'b1;
                    cnt <= '0;
                    state <= is_ir ? DBGH_SEL_IR : DBGH_CAPTURE;
                end
                // one more high step reaches the instruction column
                DBGH_SEL_IR: if (fall) begin
                    tms <= 1'b1;
                    cnt <= '0;
                    state <= DBGH_CAPTURE;
                end
                // two low steps: select to capture, then capture to shift;
                // no tdi bit goes out before the device really is in shift
                DBGH_CAPTURE: if (fall) begin
                    tms <= 1'b0;
                    cnt <= cnt + 7'h01;
                    if (cnt != '0) begin
                        cnt <= '0;
                        shreg <= is_ir ? {28'h0, ir_word} : dr_out;
                        state <= DBGH_SHIFT;
                    end
                end
                // one bit out per fall; each fall after the first takes the
                // tdo bit that the device showed at the fall before
                DBGH_SHIFT: if (fall) begin
                    if (cnt != '0) begin
                        shreg <= {tdo_s2, shreg[31:1]};
                    end
                    tdi <= (cnt == '0) ? shreg[0] : shreg[1];
                    tms <= (6'(cnt) == last_bit);
                    cnt <= cnt + 7'h01;
                    if (6'(cnt) == last_bit) begin
                        state <= DBGH_EXIT1;
                    end
                end
                // [RULE_12] exit1 then update latches
                DBGH_EXIT1: if (fall) begin
                    shreg <= {tdo_s2, shreg[31:1]};
                    tms <= 1'b1;
                    state <= DBGH_UPDATE;
                end
                // [RULE_14] update-dr latch point
                DBGH_UPDATE: if (fall) begin
                    // [RULE_15] straight on to a data scan
                    // the high step lands in data select, so capture comes next
                    if (is_ir && skip_idle) begin
                        tms <= 1'b1;
                        is_ir <= 1'b0;
                        cnt <= '0;
                        state <= DBGH_CAPTURE;
                    end else begin
                        tms <= 1'b0;
                        state <= DBGH_RUN;
                    end
                end
                // leave on the rise into idle; tck then rests high at once
                DBGH_RUN: if (tick && !tck) begin
                    state <= DBGH_IDLE;
                end
                default: state <= DBGH_IDLE;
            endcase
        end
    end

    // [RULE_14] result word moves only at the update step
    // keeps the last result readable while the next scan shifts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dr_in <= '0;
        end else if (state == DBGH_UPDATE && fall) begin
            dr_in <= shreg >> (6'd32 - (last_bit + 6'h01));
        end
    end

    // done flag: cleared by a new go, set when the run step ends;
    // a scan refused in wire mode is reported done at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else if (state == DBGH_IDLE && go_req) begin
            done <= sw_mode && !pwdata[DBGH_SWD_BIT] && !pwdata[DBGH_TLR_BIT];
        end else if (state == DBGH_RUN && tick && !tck) begin
            done <= 1'b1;
        end
    end

    // [RULE_02] scan port off once the switch pattern is out
    // sticky until bus reset: nothing here brings the scan port back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_mode <= 1'b0;
        end else if (state == DBGH_SWITCH && fall && cnt == DBGH_SWD_LEN + 7'h10) begin
            sw_mode <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- dv/dbgh_ctrl_props.sv ----
// assertion checker for the scan debug host bus and pins
`default_nettype none
module dbgh_ctrl_props
    import dbgh_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    // decode of the six host words
    assign mapped = paddr inside {DBGH_CTRL_OFF, DBGH_IR_OFF, DBGH_DR_OUT_OFF,
        DBGH_DR_IN_OFF, DBGH_STAT_OFF, DBGH_LEN_OFF};
    sequence s_high4;
        tck [*4];
    endsequence
    sequence s_low4;
        !tck [*4];
    endsequence
    a_tck_high_half: assert property ($rose(tck) |-> s_high4)
        else $error("tck high phase too short");
    a_tck_low_half: assert property ($fell(tck) |-> s_low4)
        else $error("tck low phase too short");
    // pins only move while tck is low, so the device rise sees them settled
    a_pins_settled: assert property (tck && $past(tck) |-> $stable(tms) && $stable(tdi))
        else $error("tms or tdi moved while tck high");
    a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_read_zero: assert property (psel && !penable && !pwrite && !mapped |=> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("access phase stretched");
endmodule
bind dbgh_ctrl dbgh_ctrl_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi));
`default_nettype wire

// ---- dv/dbgh_dev_model.sv ----
// behavioural model of the device test access port
`default_nettype none
module dbgh_dev_model
    import dbgh_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = 32'h0a5c3001, // arbitrary value
    parameter logic [3:0] INS_ID = 4'h2,
    parameter logic [3:0] INS_BYP = 4'hf
)(
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic reset_n,
    output logic tdo,
    output logic core_hold,
    output logic sw_mode
);
    int st = 0;
    int n_rti = 0;
    logic [3:0] ir = INS_ID;
    logic [3:0] ir_sh = 4'h0;
    logic [31:0] dr = 32'h0;
    logic [15:0] sh = 16'h0;
    initial begin
        tdo = 1'b0;
        core_hold = 1'b0;
        sw_mode = 1'b0;
    end
    // numbering: 0 reset, 1 idle, 2-8 data column, 9-15 instruction column
    function automatic int nx(input int s, input logic m);
        case (s)
            0: return m ? 0 : 1;
            1: return m ? 2 : 1;
            2: return m ? 9 : 3;
            3, 4: return m ? 5 : 4;
            5: return m ? 8 : 6;
            6: return m ? 7 : 6;
            7: return m ? 8 : 4;
            8, 15: return m ? 2 : 1;
            9: return m ? 0 : 10;
            10, 11: return m ? 12 : 11;
            12: return m ? 15 : 13;
            13: return m ? 14 : 13;
            default: return m ? 15 : 11;
        endcase
    endfunction
    // walk and register actions on rising edges
    always @(posedge tck) begin
        if (st != 1 && nx(st, tms) == 1) n_rti <= n_rti + 1;
        st <= nx(st, tms);
        sh <= {tms, sh[15:1]};
        case (st)
            0: ir <= INS_ID;
            3: dr <= (ir == INS_ID) ? ID_VALUE : 32'h0;
            4: dr <= (ir == INS_BYP) ? {31'h0, tdi} : {tdi, dr[31:1]};
            10: ir_sh <= 4'h1;
            11: ir_sh <= {tdi, ir_sh[3:1]};
            15: ir <= ir_sh;
            default: ;
        endcase
        if (sh == DBGH_SWD_SEQ) sw_mode <= 1'b1;
    end
    // data out on falls; a released line toggles
    always @(negedge tck) begin
        if (!sw_mode && st == 11) tdo <= ir_sh[0];
        else if (!sw_mode && st == 4) tdo <= dr[0];
        else tdo <= !tdo;
    end
    // test clock level at reset release decides the core hold
    always @(posedge reset_n) core_hold <= !tck;
endmodule
`default_nettype wire

// ---- dv/dbgh_ctrl_bench.sv ----
// self-checking bench for the scan debug host
`default_nettype none
module dbgh_ctrl_bench
    import dbgh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] GO = 32'h1 << DBGH_GO_BIT;
    localparam logic [31:0] KIND = 32'h1 << DBGH_KIND_BIT;
    localparam logic [31:0] TLR = 32'h1 << DBGH_TLR_BIT;
    localparam logic [31:0] SWD = 32'h1 << DBGH_SWD_BIT;
    localparam logic [31:0] HOLD = 32'h1 << DBGH_HOLD_BIT;
    localparam logic [31:0] RST = 32'h1 << DBGH_RST_BIT;
    localparam logic [31:0] SKIP = 32'h1 << DBGH_SKIP_BIT;
    localparam logic [31:0] ID_VALUE = 32'h0a5c3001; // arbitrary value
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, tck, tms, tdi, tdo, rst_n, core_hold, sw_mode, rerr;
    int n_errors = 0, num_checks = 0, cyc = 0;
    always #50 pclk = !pclk;
    dbgh_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .reset_n_out(rst_n));
    dbgh_dev_model #(.ID_VALUE(ID_VALUE)) dev_u (.tck(tck), .tms(tms), .tdi(tdi),
        .reset_n(rst_n), .tdo(tdo), .core_hold(core_hold), .sw_mode(sw_mode));
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one bus transfer; a leading edge keeps back-to-back calls from clashing
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // start a sequence and poll busy; leaves the final status in rdata
    task automatic run_op(input logic [31:0] c);
        int n;
        n = 0;
        apb(1'b1, DBGH_CTRL_OFF, c);
        do begin
            apb(1'b0, DBGH_STAT_OFF, 32'h0);
            n++;
        end while (rdata[DBGH_BUSY_BIT] !== 1'b0 && n < 500);
    endtask
    task automatic t_regs();
        apb(1'b0, DBGH_LEN_OFF, 32'h0);
        chk(rdata, 32'(DBGH_LEN_RESET));
        apb(1'b1, 12'h018, 32'hffffffff);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, 12'h018, 32'h0);
        chk({rdata[31:1], rdata[0] ^ rerr}, 32'h1);
    endtask
    task automatic t_idcode();
        run_op(TLR | GO);
        chk(32'(dev_u.st), 32'h1);
        run_op(GO);
        chk(rdata, 32'h4);
        apb(1'b0, DBGH_DR_IN_OFF, 32'h0);
        chk(rdata, ID_VALUE);
    endtask
    task automatic t_scan();
        logic [3:0] ins [3];
        ins = '{DBGH_INS_SAMPLE, DBGH_INS_INTEST, 4'hf};
        // each instruction loads, and capture shows the fixed pattern
        foreach (ins[i]) begin
            apb(1'b1, DBGH_IR_OFF, {28'h0, ins[i]});
            run_op(GO | KIND);
            apb(1'b0, DBGH_DR_IN_OFF, 32'h0);
            chk({28'h0, rdata[3:0]}, 32'h1);
            chk({28'h0, dev_u.ir}, {28'h0, ins[i]});
        end
        apb(1'b1, DBGH_LEN_OFF, 32'h8);
        apb(1'b1, DBGH_DR_OUT_OFF, 32'ha5);
        run_op(GO);
        apb(1'b0, DBGH_DR_IN_OFF, 32'h0);
        chk({24'h0, rdata[7:0]}, 32'h4a);
    endtask
    task automatic t_skip();
        int n0;
        n0 = dev_u.n_rti;
        apb(1'b1, DBGH_IR_OFF, 32'h2);
        apb(1'b1, DBGH_LEN_OFF, 32'h20);
        run_op(GO | KIND | SKIP);
        apb(1'b0, DBGH_DR_IN_OFF, 32'h0);
        chk(rdata, ID_VALUE);
        chk(32'(dev_u.n_rti - n0), 32'h1);
    endtask
    task automatic t_hold();
        apb(1'b1, DBGH_CTRL_OFF, HOLD | RST);
        apb(1'b0, DBGH_STAT_OFF, 32'h0);
        chk({30'h0, tck, rst_n}, 32'h0);
        apb(1'b1, DBGH_CTRL_OFF, HOLD);
        apb(1'b0, DBGH_STAT_OFF, 32'h0);
        chk({30'h0, core_hold, rst_n}, 32'h3);
        apb(1'b1, DBGH_CTRL_OFF, RST);
        apb(1'b1, DBGH_CTRL_OFF, 32'h0);
        apb(1'b0, DBGH_STAT_OFF, 32'h0);
        chk({30'h0, core_hold, rst_n}, 32'h1);
    endtask
    // wire mode sticks until bus reset, so this runs last
    task automatic t_swd();
        run_op(GO | SWD);
        chk({31'h0, sw_mode}, 32'h1);
        chk(rdata, 32'h6);
        run_op(GO);
        chk(rdata, 32'h6);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_idcode();
        t_scan();
        t_skip();
        t_hold();
        t_swd();
        finish_test();
    end
    // hang guard well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            finish_test();
        end
    end
endmodule
`default_nettype wire
